// file: design/lvm_ctrl.sv
// Supply monitor control: register, comparator steering, alarm delay, interrupt
module lvm_ctrl (
  // Clock and reset
  input  wire logic       MCLK,
  input  wire logic       ARST_N,
  // Register port
  input  wire logic [3:0] REG_ADDR,
  input  wire logic [7:0] REG_WDATA,
  input  wire logic       REG_WR,
  input  wire logic       REG_RD,
  output logic      [7:0] REG_RDATA,
  // Power mode and system status
  input  wire logic       SLEEP_MODE,
  input  wire logic       IDLE_MODE,
  input  wire logic       UV_RESET_EN,
  // Analogue comparator side
  input  wire logic       CMP_OUT,
  output logic            CMP_ENABLE,
  output logic            SENSE_EXT,
  output logic      [2:0] THRESHOLD_CODE,
  output logic            BANDGAP_ENABLE,
  // Interrupt and wake
  output logic            IRQ,
  output logic            WAKE_IDLE
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [7:0] ctrl_q;
  logic [7:0] ctrl_d;
  logic [1:0] status_q;
  logic [1:0] status_d;
  logic [1:0] mask_q;
  logic [1:0] mask_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic [9:0] div_q;
  logic [9:0] div_d;
  logic       uv_prev_q;
  logic       cmp_en_q;
  logic       sense_ext_q;
  logic [2:0] thr_code_q;
  logic       bandgap_q;
  logic       wake_q;
  logic       wake_d;

  logic       wr_ctrl;
  logic       wr_status;
  logic       wr_mask;
  logic       wr_force;
  logic       rd_hit_ctrl;
  logic       rd_hit_status;
  logic       rd_hit_mask;
  logic [2:0] thr_sel;
  logic       monitor_enable;
  logic       reference_force_on;
  logic [1:0] alarm_delay_select;
  logic       det_active;
  logic       cmp_sync;
  logic       undervoltage_flag;
  logic       slow_tick;
  logic       alarm_pulse;
  logic [3:0] ticks_seen;
  logic [3:0] ticks_need;
  logic [1:0] irq_set;
  logic [1:0] irq_clr;
  logic [7:0] ctrl_view;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  assign wr_ctrl       = REG_WR && (REG_ADDR == lvm_pkg::OFS_CONTROL);
  assign wr_status     = REG_WR && (REG_ADDR == lvm_pkg::OFS_IRQ_STATUS);
  assign wr_mask       = REG_WR && (REG_ADDR == lvm_pkg::OFS_IRQ_MASK);
  assign wr_force      = REG_WR && (REG_ADDR == lvm_pkg::OFS_IRQ_FORCE);
  assign rd_hit_ctrl   = REG_ADDR == lvm_pkg::OFS_CONTROL;
  assign rd_hit_status = REG_ADDR == lvm_pkg::OFS_IRQ_STATUS;
  assign rd_hit_mask   = REG_ADDR == lvm_pkg::OFS_IRQ_MASK;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  assign thr_sel            = ctrl_q[lvm_pkg::CTL_THR_MSB:lvm_pkg::CTL_THR_LSB];
  assign reference_force_on = ctrl_q[lvm_pkg::CTL_REF_ON];
  assign monitor_enable     = ctrl_q[lvm_pkg::CTL_ENABLE];
  assign alarm_delay_select = ctrl_q[lvm_pkg::CTL_DLY_MSB:lvm_pkg::CTL_DLY_LSB];

  // Writable bits only; the flag bit is never stored
  assign ctrl_d = wr_ctrl ? (REG_WDATA & lvm_pkg::CTL_WR_MASK) : ctrl_q;

  // Control register, all zero after power-on
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ctrl_q <= lvm_pkg::CTL_RESET;
    end else begin
      ctrl_q <= ctrl_d;
    end
  end

  // ----------------------------------------------------------------
  // Detector enable and analogue steering
  // ----------------------------------------------------------------
  // Sleep overrides the enable bit
  assign det_active = monitor_enable && !SLEEP_MODE;

  // Registered drive of the analogue block
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      cmp_en_q    <= 1'b0;
      sense_ext_q <= 1'b0;
      thr_code_q  <= 3'h0;
      bandgap_q   <= 1'b0;
    end else begin
      cmp_en_q    <= det_active;
      sense_ext_q <= thr_sel == lvm_pkg::THR_EXTERNAL;
      thr_code_q  <= thr_sel;
      bandgap_q   <= det_active || UV_RESET_EN || reference_force_on;
    end
  end

  assign CMP_ENABLE     = cmp_en_q;
  assign SENSE_EXT      = sense_ext_q;
  assign THRESHOLD_CODE = thr_code_q;
  assign BANDGAP_ENABLE = bandgap_q;

  // ----------------------------------------------------------------
  // Comparator sampling
  // ----------------------------------------------------------------
  lvm_sync u_sync (
    .clk    (MCLK),
    .arst_n (ARST_N),
    .din    (CMP_OUT),
    .dout   (cmp_sync)
  );

  // Raw comparator level, no hysteresis; zero while detector is off
  assign undervoltage_flag = cmp_sync && det_active;

  // ----------------------------------------------------------------
  // Slow oscillator period enable
  // ----------------------------------------------------------------
  assign div_d = (div_q == 10'(lvm_pkg::SLOW_DIV_CYC - 1)) ? 10'h000 : div_q + 10'h001;
  assign slow_tick = div_q == 10'(lvm_pkg::SLOW_DIV_CYC - 1);

  // Free-running divider
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      div_q <= 10'h000;
    end else begin
      div_q <= div_d;
    end
  end

  // ----------------------------------------------------------------
  // Alarm delay filter
  // ----------------------------------------------------------------
  lvm_delay u_delay (
    .clk        (MCLK),
    .arst_n     (ARST_N),
    .slow_tick  (slow_tick),
    .delay_sel  (alarm_delay_select),
    .uv_level   (undervoltage_flag),
    .alarm      (alarm_pulse),
    .ticks_seen (ticks_seen),
    .ticks_need (ticks_need)
  );

  // ----------------------------------------------------------------
  // Interrupt status, mask and force
  // ----------------------------------------------------------------
  assign irq_set[lvm_pkg::IRQ_ALARM]   = alarm_pulse || (wr_force && REG_WDATA[0]);
  assign irq_set[lvm_pkg::IRQ_UV_RISE] = undervoltage_flag && !uv_prev_q;
  assign irq_clr  = wr_status ? REG_WDATA[1:0] : 2'h0;
  // Set wins over a clear in the same cycle
  assign status_d = (status_q & ~irq_clr) | irq_set;
  assign mask_d   = wr_mask ? REG_WDATA[1:0] : mask_q;

  // Status, mask and edge history
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      status_q  <= lvm_pkg::IRQ_RESET;
      mask_q    <= lvm_pkg::IRQ_RESET;
      uv_prev_q <= 1'b0;
    end else begin
      status_q  <= status_d;
      mask_q    <= mask_d;
      uv_prev_q <= undervoltage_flag;
    end
  end

  assign IRQ = |(status_q & mask_q);

  // Wake only on the alarm flag newly set during idle; a flag preset before idle
  // gives no wake, so software can opt out. Held until idle ends.
  assign wake_d = IDLE_MODE && (wake_q || (status_d[lvm_pkg::IRQ_ALARM] &&
                  !status_q[lvm_pkg::IRQ_ALARM]));

  // Wake request register
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      wake_q <= 1'b0;
    end else begin
      wake_q <= wake_d;
    end
  end

  assign WAKE_IDLE = wake_q;

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  assign ctrl_view = {ctrl_q[7:6], undervoltage_flag, ctrl_q[4:0]};
  assign rdata_d   = !REG_RD      ? 8'h00 :
                     rd_hit_ctrl   ? ctrl_view :
                     rd_hit_status ? {6'h00, status_q} :
                     rd_hit_mask   ? {6'h00, mask_q} : 8'h00;

  // Read data stands one cycle after the strobe
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign REG_RDATA = rdata_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  chk_sense_ext_sel: assert property (
    @(posedge MCLK) disable iff (!ARST_N)
    ARST_N |=> (SENSE_EXT == ($past(thr_sel) == 3'h0)))
    else $error("external sense select wrong");

  chk_threshold_code: assert property (
    @(posedge MCLK) disable iff (!ARST_N)
    wr_ctrl |=> ##1 (THRESHOLD_CODE == $past(REG_WDATA[2:0], 2)))
    else $error("threshold code not following write");

  chk_flag_readback: assert property (
    @(posedge MCLK) disable iff (!ARST_N)
    (REG_RD && rd_hit_ctrl) |=> (REG_RDATA[5] == $past(undervoltage_flag)))
    else $error("undervoltage flag readback wrong");

  chk_enable_off: assert property (
    @(posedge MCLK) disable iff (!ARST_N)
    (wr_ctrl && !REG_WDATA[4]) |=> ##1 !CMP_ENABLE)
    else $error("detector still on after disable");

  chk_sleep_off: assert property (
    @(posedge MCLK) disable iff (!ARST_N)
    SLEEP_MODE |=> !CMP_ENABLE)
    else $error("detector on during sleep");

  chk_alarm_held: assert property (
    @(posedge MCLK) disable iff (!ARST_N)
    alarm_pulse |-> undervoltage_flag ##1 status_q[0])
    else $error("alarm without held level or flag not set");

  chk_delay_count: assert property (
    @(posedge MCLK) disable iff (!ARST_N)
    alarm_pulse |-> (ticks_seen == ticks_need && ticks_need != 4'h0))
    else $error("alarm before delay elapsed");

  chk_idle_wake: assert property (
    @(posedge MCLK) disable iff (!ARST_N)
    (IDLE_MODE && status_d[lvm_pkg::IRQ_ALARM] && !status_q[lvm_pkg::IRQ_ALARM])
      |=> WAKE_IDLE)
    else $error("no wake from idle");

  chk_bandgap_on: assert property (
    @(posedge MCLK) disable iff (!ARST_N)
    (UV_RESET_EN || reference_force_on) |=> BANDGAP_ENABLE)
    else $error("bandgap not enabled");

  chk_sync_path: assert property (
    @(posedge MCLK) disable iff (!ARST_N)
    ($past(ARST_N) && $past(ARST_N, 2) && det_active) |->
      (undervoltage_flag == $past(CMP_OUT, 2)))
    else $error("sync path broken");

  chk_flag_ro: assert property (
    @(posedge MCLK) disable iff (!ARST_N)
    wr_ctrl |=> !ctrl_q[lvm_pkg::CTL_UV_FLAG])
    else $error("read-only flag bit stored");

  chk_flag_off_read: assert property (
    @(posedge MCLK) disable iff (!ARST_N)
    (REG_RD && rd_hit_ctrl && !det_active) |=> !REG_RDATA[lvm_pkg::CTL_UV_FLAG])
    else $error("flag reads set while detector off");

  chk_alarm_once: assert property (
    @(posedge MCLK) disable iff (!ARST_N)
    alarm_pulse |=> !alarm_pulse)
    else $error("alarm repeated within one episode");

  chk_delay_restart: assert property (
    @(posedge MCLK) disable iff (!ARST_N)
    !undervoltage_flag |=> (ticks_seen == 4'h0))
    else $error("delay count kept across a high level");

  chk_preset_no_wake: assert property (
    @(posedge MCLK) disable iff (!ARST_N)
    (IDLE_MODE && status_q[lvm_pkg::IRQ_ALARM] && !WAKE_IDLE) |=> !WAKE_IDLE)
    else $error("preset flag woke the device");

  chk_force_set: assert property (
    @(posedge MCLK) disable iff (!ARST_N)
    (wr_force && REG_WDATA[0]) |=> status_q[lvm_pkg::IRQ_ALARM])
    else $error("forced flag not set");

  chk_bandgap_off: assert property (
    @(posedge MCLK) disable iff (!ARST_N)
    !(det_active || UV_RESET_EN || reference_force_on) |=> !BANDGAP_ENABLE)
    else $error("bandgap on without a source");

  chk_ctrl_reset: assert property (
    @(posedge MCLK) disable iff (!ARST_N)
    $rose(ARST_N) |-> (ctrl_q == lvm_pkg::CTL_RESET))
    else $error("control register not zero after reset");

  cov_alarm: cover property (@(posedge MCLK) disable iff (!ARST_N) alarm_pulse);
  cov_preset: cover property (@(posedge MCLK) disable iff (!ARST_N)
    IDLE_MODE && status_q[lvm_pkg::IRQ_ALARM] && !WAKE_IDLE);
  cov_wake: cover property (@(posedge MCLK) disable iff (!ARST_N) $rose(WAKE_IDLE));
  cov_ext: cover property (@(posedge MCLK) disable iff (!ARST_N) SENSE_EXT && CMP_ENABLE);

endmodule // lvm_ctrl

// file: design/lvm_delay.sv
// Alarm delay filter counting slow periods of a held low-voltage level
module lvm_delay (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       arst_n,
  // Timing
  input  wire logic       slow_tick,
  input  wire logic [1:0] delay_sel,
  // Level and result
  input  wire logic       uv_level,
  output logic            alarm,
  output logic [3:0]      ticks_seen,
  output logic [3:0]      ticks_need
);

  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  logic       done_q;
  logic       done_d;
  logic       reach;

  // Required count per delay code
  assign ticks_need = (delay_sel == 2'h0) ? lvm_pkg::DLY_TICKS_00 :
                      (delay_sel == 2'h1) ? lvm_pkg::DLY_TICKS_01 :
                      (delay_sel == 2'h2) ? lvm_pkg::DLY_TICKS_10 :
                                            lvm_pkg::DLY_TICKS_11;

  // Count only while the level holds; a short pulse restarts from zero
  assign reach  = uv_level && !done_q && (cnt_q >= ticks_need);
  assign cnt_d  = !uv_level ? 4'h0 :
                  (slow_tick && cnt_q < ticks_need) ? cnt_q + 4'h1 : cnt_q;
  assign done_d = uv_level && (done_q || reach);
  assign alarm  = reach;
  assign ticks_seen = cnt_q;

  // Counter and once-per-episode latch
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q  <= 4'h0;
      done_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      done_q <= done_d;
    end
  end

endmodule // lvm_delay

// file: design/lvm_pkg.sv
// Constants shared by the supply monitor control logic
package lvm_pkg;

  // ----------------------------------------------------------------
  // Register bus geometry
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [3:0] OFS_CONTROL = 4'h0;
  localparam logic [3:0] OFS_IRQ_STATUS = 4'h1;
  localparam logic [3:0] OFS_IRQ_MASK = 4'h2;
  localparam logic [3:0] OFS_IRQ_FORCE = 4'h3;

  // ----------------------------------------------------------------
  // Control register field positions and reset value
  // ----------------------------------------------------------------
  localparam int unsigned CTL_THR_LSB = 0;
  localparam int unsigned CTL_THR_MSB = 2;
  localparam int unsigned CTL_REF_ON = 3;
  localparam int unsigned CTL_ENABLE = 4;
  localparam int unsigned CTL_UV_FLAG = 5;
  localparam int unsigned CTL_DLY_LSB = 6;
  localparam int unsigned CTL_DLY_MSB = 7;
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [7:0] CTL_WR_MASK = 8'hdf;

  // Threshold code that senses the external input
  localparam logic [2:0] THR_EXTERNAL = 3'h0;

  // ----------------------------------------------------------------
  // Interrupt status bits
  // ----------------------------------------------------------------
  localparam int unsigned IRQ_W = 2;
  localparam int unsigned IRQ_ALARM = 0;
  localparam int unsigned IRQ_UV_RISE = 1;
  localparam logic [1:0] IRQ_RESET = 2'h0;

  // ----------------------------------------------------------------
  // Timing: slow oscillator period derived from the 20 MHz clock
  // ----------------------------------------------------------------
  localparam int unsigned MCLK_PERIOD_NS = 50;
  localparam int unsigned SLOW_OSC_PERIOD_NS = 31250;
  localparam int unsigned SLOW_DIV_CYC = SLOW_OSC_PERIOD_NS / MCLK_PERIOD_NS;
  localparam int unsigned SLOW_DIV_W = 10;

  // Slow periods counted per alarm delay code (upper bound of each range)
  localparam int unsigned DLY_CNT_W = 4;
  localparam logic [3:0] DLY_TICKS_00 = 4'h2;
  localparam logic [3:0] DLY_TICKS_01 = 4'h4;
  localparam logic [3:0] DLY_TICKS_10 = 4'h8;
  localparam logic [3:0] DLY_TICKS_11 = 4'h2;

endpackage : lvm_pkg

// file: design/lvm_sync.sv
// Two-stage synchroniser for the comparator output
module lvm_sync (
  // Clock and reset
  input  wire logic clk,
  input  wire logic arst_n,
  // Level in and out
  input  wire logic din,
  output logic      dout
);

  logic meta_q;
  logic sync_q;

  // First stage read only by the second
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= din;
      sync_q <= meta_q;
    end
  end

  assign dout = sync_q;

endmodule // lvm_sync

// file: tb/lvm_cmp_model.sv
// Behavioural model of the analogue undervoltage comparator
module lvm_cmp_model (
  // Clock
  input  wire logic        clk,
  // Steering from the monitor
  input  wire logic        cmp_enable,
  input  wire logic        sense_ext,
  input  wire logic [2:0]  threshold_code,
  // Analogue levels in millivolts
  input  wire logic [15:0] supply_mv,
  input  wire logic [15:0] ext_mv,
  // Result, 1 = below threshold
  output logic             cmp_out
);
  timeunit 1ns;
  timeprecision 100ps;

  // Reference for code 000, then supply thresholds for 001 to 111
  localparam int THR_MV [8] = '{1230, 2200, 2400, 2700, 3000, 3300, 3600, 4000};

  logic tog_q = 1'b0;
  logic below;

  // Unpowered output wanders every cycle
  always @(posedge clk) tog_q <= ~tog_q;

  // No hysteresis: result follows the levels directly
  assign below = sense_ext ? (ext_mv < THR_MV[0]) : (supply_mv < THR_MV[threshold_code]);
  assign cmp_out = cmp_enable ? below : tog_q;
endmodule // lvm_cmp_model

// file: tb/test_low_voltage_monitor_ctrl.sv
// Self-checking bench for the supply monitor control block
module test_low_voltage_monitor_ctrl;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int DIV = lvm_pkg::SLOW_DIV_CYC;
  localparam int LO_T [4] = '{1, 3, 7, 1};
  localparam int HI_T [4] = '{2, 4, 8, 2};

  logic        mclk = 1'b0;
  logic        arst_n = 1'b0;
  logic [3:0]  reg_addr = 4'h0;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        sleep_mode = 1'b0;
  logic        idle_mode = 1'b0;
  logic        uv_reset_en = 1'b0;
  logic [15:0] supply_mv = 16'h1388;
  logic [15:0] ext_mv = 16'h1388;
  logic [7:0]  reg_rdata;
  logic [2:0]  threshold_code;
  logic        cmp_out, cmp_enable, sense_ext, bandgap_enable, irq, wake_idle;
  logic [7:0]  rd_v;
  logic [15:0] lo, hi;
  int          errors = 0;
  int          num_checks = 0;
  int          n;

  // Clock at 20 MHz
  always #25 mclk = ~mclk;

  lvm_ctrl lvm_ctrl_inst (.MCLK(mclk), .ARST_N(arst_n), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
    .SLEEP_MODE(sleep_mode), .IDLE_MODE(idle_mode), .UV_RESET_EN(uv_reset_en),
    .CMP_OUT(cmp_out), .CMP_ENABLE(cmp_enable), .SENSE_EXT(sense_ext),
    .THRESHOLD_CODE(threshold_code), .BANDGAP_ENABLE(bandgap_enable), .IRQ(irq),
    .WAKE_IDLE(wake_idle));

  lvm_cmp_model lvm_cmp_model_inst (.clk(mclk), .cmp_enable(cmp_enable),
    .sense_ext(sense_ext), .threshold_code(threshold_code), .supply_mv(supply_mv),
    .ext_mv(ext_mv), .cmp_out(cmp_out));

  // ----------------------------------------------------------------
  // Register port tasks
  // ----------------------------------------------------------------
  task automatic cyc(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic chk_rd(input string nm, input logic [3:0] a, input logic [7:0] e);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    rd_v = reg_rdata;
    chk(nm, e, rd_v);
  endtask

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge mclk);
    arst_n <= 1'b1;
    cyc(1);
    chk_rd("control", lvm_pkg::OFS_CONTROL, 8'h00);
    chk_rd("status", lvm_pkg::OFS_IRQ_STATUS, 8'h00);
    chk_rd("mask", lvm_pkg::OFS_IRQ_MASK, 8'h00);
    chk("outs", 8'h10, {2'h0, cmp_enable, sense_ext, bandgap_enable, threshold_code});
    wr(4'h7, 8'hff);
    chk_rd("unmapped", 4'h7, 8'h00);
    chk_rd("control kept", lvm_pkg::OFS_CONTROL, 8'h00);
    $display("test reset done");
    // Every threshold code, target input below and above
    for (int c = 0; c < 8; c++) begin
      wr(lvm_pkg::OFS_CONTROL, 8'h30 | 8'(c));
      cyc(10);
      chk("steer", {2'h0, 1'b1, c == 0, 1'b1, 3'(c)},
          {2'h0, cmp_enable, sense_ext, bandgap_enable, threshold_code});
      lo = 16'(lvm_cmp_model_inst.THR_MV[c] - 50);
      hi = 16'(lvm_cmp_model_inst.THR_MV[c] + 50);
      ext_mv <= (c == 0) ? lo : 16'h1388;
      supply_mv <= (c == 0) ? 16'h1388 : lo;
      cyc(4);
      chk_rd("flag low", lvm_pkg::OFS_CONTROL, 8'h30 | 8'(c));
      ext_mv <= (c == 0) ? hi : 16'h03e8;
      supply_mv <= (c == 0) ? 16'h03e8 : hi;
      cyc(4);
      chk_rd("flag high", lvm_pkg::OFS_CONTROL, 8'h10 | 8'(c));
    end
    $display("test steering done");
    // Reference enables and sleep
    wr(lvm_pkg::OFS_CONTROL, 8'h00);
    cyc(2);
    chk("bandgap off", 8'h00, {6'h0, cmp_enable, bandgap_enable});
    uv_reset_en <= 1'b1;
    cyc(3);
    chk("bandgap reset", 8'h01, {7'h0, bandgap_enable});
    uv_reset_en <= 1'b0;
    wr(lvm_pkg::OFS_CONTROL, 8'h08);
    cyc(2);
    chk("bandgap force", 8'h01, {7'h0, bandgap_enable});
    wr(lvm_pkg::OFS_CONTROL, 8'h11);
    supply_mv <= 16'h03e8;
    sleep_mode <= 1'b1;
    cyc(4);
    chk("sleep outs", 8'h00, {6'h0, cmp_enable, bandgap_enable});
    chk_rd("sleep flag", lvm_pkg::OFS_CONTROL, 8'h11);
    sleep_mode <= 1'b0;
    cyc(10);
    chk_rd("wake flag", lvm_pkg::OFS_CONTROL, 8'h31);
    supply_mv <= 16'h1388;
    $display("test power done");
    // Alarm delay per code: short pulse refused, held level raises flag
    wr(lvm_pkg::OFS_IRQ_MASK, 8'h01);
    for (int d = 0; d < 4; d++) begin
      wr(lvm_pkg::OFS_CONTROL, 8'(d << 6) | 8'h11);
      cyc(4);
      wr(lvm_pkg::OFS_IRQ_STATUS, 8'h03);
      supply_mv <= 16'h03e8;
      cyc(LO_T[d] * DIV - 20);
      supply_mv <= 16'h1388;
      cyc(4);
      chk_rd("short pulse", lvm_pkg::OFS_IRQ_STATUS, 8'h02);
      chk("irq short", 8'h00, {7'h0, irq});
      wr(lvm_pkg::OFS_IRQ_STATUS, 8'h03);
      idle_mode <= 1'b1;
      supply_mv <= 16'h03e8;
      n = 0;
      while (irq !== 1'b1 && n < 9000) begin
        cyc(1);
        n++;
      end
      chk("alarm width", 8'h01, 8'(n >= LO_T[d] * DIV && n <= HI_T[d] * DIV + 6));
      chk_rd("alarm status", lvm_pkg::OFS_IRQ_STATUS, 8'h03);
      wr(lvm_pkg::OFS_IRQ_MASK, 8'h00);
      cyc(1);
      chk("irq masked", 8'h00, {7'h0, irq});
      chk("wake", 8'h01, {7'h0, wake_idle});
      idle_mode <= 1'b0;
      wr(lvm_pkg::OFS_IRQ_MASK, 8'h01);
      supply_mv <= 16'h1388;
      cyc(4);
      wr(lvm_pkg::OFS_IRQ_STATUS, 8'h03);
      cyc(1);
      chk("irq cleared", 8'h00, {7'h0, irq});
    end
    $display("test alarm done");
    // Software presets the flag before idle
    wr(lvm_pkg::OFS_IRQ_FORCE, 8'h01);
    chk_rd("forced", lvm_pkg::OFS_IRQ_STATUS, 8'h01);
    chk("irq forced", 8'h01, {7'h0, irq});
    idle_mode <= 1'b1;
    cyc(3);
    chk("preset no wake", 8'h00, {7'h0, wake_idle});
    idle_mode <= 1'b0;
    $display("test force done");
    summarize();
  end

  // Watchdog sized well beyond the alarm tests
  initial begin
    #(40000 * 50);
    errors++;
    $display("[ERR] watchdog expected finish seen timeout");
    summarize();
  end
endmodule // test_low_voltage_monitor_ctrl
